// File: hw/mcu_interrupt_controller.sv
// Interrupt controller: request flags, enables, priority, return stack.
// Assumes APB master on clk_sys, single-cycle event pulses from sources,
// and a core that raises insn_boundary when it may be redirected.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/10ps
module mcu_interrupt_controller (
    input  wire logic                        clk_sys,
    input  wire logic                        rst_n,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [irqc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Event sources
    input  wire logic [irqc_pkg::N_EXT-1:0]  ext_pin_in,
    input  wire logic [irqc_pkg::N_TM-1:0]   tm_match_a,
    input  wire logic [irqc_pkg::N_TM-1:0]   tm_match_p,
    input  wire logic                        tb0_tick,
    input  wire logic                        tb1_tick,
    input  wire logic                        nvm_write_done,
    input  wire logic                        low_voltage_evt,
    input  wire logic                        conv_done,
    // Core side
    input  wire logic                        insn_boundary,
    input  wire logic [irqc_pkg::PC_W-1:0]   next_pc,
    input  wire logic                        call_push,
    input  wire logic                        ret_pop,
    input  wire logic                        return_from_interrupt,
    output logic                             pc_load,
    output logic      [irqc_pkg::PC_W-1:0]   pc_load_addr,
    output logic                             irq_taken,
    output logic                             stack_full,
    output logic                             wake_req,
    output logic      [irqc_pkg::N_EXT-1:0]  ext_pin_func_sel
);
    localparam logic [irqc_pkg::N_SRC-1:0] SRC_ONE = 9'h001;

    // Reset synchroniser
    logic rst_meta_ff;                       // First stage, read by second only
    logic rst_core_n;                        // Released copy used everywhere

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_core_n  <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_core_n  <= rst_meta_ff;
        end
    end

    // Control and flag state
    logic                         global_irq_enable_ff;   // Global enable
    logic [7:0]                   edge_sel_ff;            // Edge select register
    logic [irqc_pkg::N_EXT-1:0]   ext_pin_request_flag_ff;
    logic [irqc_pkg::N_EXT-1:0]   ext_pin_irq_enable_ff;
    logic [irqc_pkg::N_GRP-1:0]   shared_group_request_flag_ff;
    logic [irqc_pkg::N_GRP-1:0]   shared_group_enable_ff;
    logic                         conv_done_request_flag_ff;
    logic                         conv_done_irq_enable_ff;
    logic [2*irqc_pkg::N_TM-1:0]  tm_flag_ff;             // P at 2g, A at 2g+1
    logic [2*irqc_pkg::N_TM-1:0]  tm_en_ff;               // Member enables
    logic [3:0]                   aux_flag_ff;            // Aux request flags, one owner
    logic [3:0]                   aux_en_ff;              // Aux member enables, one owner
    logic [irqc_pkg::SP_W-1:0]    sp_ff;                  // Stack pointer
    logic [irqc_pkg::PC_W-1:0]    stk_mem [irqc_pkg::STK_DEPTH]; // Return stack
    logic                         pc_load_ff;
    logic [irqc_pkg::PC_W-1:0]    pc_load_addr_ff;
    logic                         irq_taken_ff;
    logic [irqc_pkg::SEL_W-1:0]   last_src_ff;            // Last serviced source
    logic [irqc_pkg::N_ALLF-1:0]  prev_flags_ff;          // Flags one cycle ago
    logic                         wake_ff;
    logic [31:0]                  prdata_ff;

    // APB decode
    wire apb_setup  = psel & ~penable;
    wire wr_go      = psel & penable & pwrite;
    wire wr_gie     = wr_go & (paddr == irqc_pkg::OFS_GIE);
    wire wr_edge    = wr_go & (paddr == irqc_pkg::OFS_EDGE);
    wire wr_ext     = wr_go & (paddr == irqc_pkg::OFS_EXT);
    wire wr_grp     = wr_go & (paddr == irqc_pkg::OFS_GRP);
    wire wr_conv    = wr_go & (paddr == irqc_pkg::OFS_CONV);
    wire wr_tm      = wr_go & (paddr == irqc_pkg::OFS_TM);
    wire wr_aux     = wr_go & (paddr == irqc_pkg::OFS_AUX);
    wire addr_hit   = (paddr == irqc_pkg::OFS_GIE)  | (paddr == irqc_pkg::OFS_EDGE)
                    | (paddr == irqc_pkg::OFS_EXT)  | (paddr == irqc_pkg::OFS_GRP)
                    | (paddr == irqc_pkg::OFS_CONV) | (paddr == irqc_pkg::OFS_TM)
                    | (paddr == irqc_pkg::OFS_AUX)  | (paddr == irqc_pkg::OFS_STAT);

    assign pready  = 1'b1;                   // Zero wait states
    assign pslverr = psel & penable & ~addr_hit;
    assign prdata  = prdata_ff;

    // Source events
    wire [irqc_pkg::N_EXT-1:0]  ext_hit;
    wire [3:0]                  aux_evt = {tb1_tick, tb0_tick, nvm_write_done, low_voltage_evt};
    wire [2*irqc_pkg::N_TM-1:0] tm_evt;
    wire [irqc_pkg::N_GRP-1:0]  grp_evt;

    irq_edge_detect u_edge (
        .clk_sys    (clk_sys),
        .rst_core_n (rst_core_n),
        .pin_in     (ext_pin_in),
        .edge_sel   (edge_sel_ff),
        .pin_en     (ext_pin_irq_enable_ff),
        .edge_hit   (ext_hit)
    );

    // Pin mux hands the pin to the interrupt path only while enabled
    assign ext_pin_func_sel = ext_pin_irq_enable_ff;

    // Group membership: timer g in group g, aux sources in one group
    genvar g;
    generate
        for (g = 0; g < irqc_pkg::N_GRP; g++) begin : g_grp
            assign tm_evt[2*g]     = tm_match_p[g];
            assign tm_evt[2*g+1]   = tm_match_a[g];
            assign grp_evt[g] = tm_match_p[g] | tm_match_a[g]
                              | ((g == irqc_pkg::AUX_GROUP) & (|aux_evt));
        end
    endgenerate

    // Pending vector and fixed priority pick
    wire [irqc_pkg::N_SRC-1:0] src_flags = {conv_done_request_flag_ff,
                                            shared_group_request_flag_ff,
                                            ext_pin_request_flag_ff};
    wire [irqc_pkg::N_SRC-1:0] src_en    = {conv_done_irq_enable_ff,
                                            shared_group_enable_ff,
                                            ext_pin_irq_enable_ff};
    wire [irqc_pkg::N_SRC-1:0] pend      = src_flags & src_en;
    logic [irqc_pkg::SEL_W-1:0] sel_idx;

    // Lowest index wins
    always_comb begin
        sel_idx = '0;
        for (int i = irqc_pkg::N_SRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                sel_idx = irqc_pkg::SEL_W'(i);
            end
        end
    end

    // Acceptance and service clears
    wire stk_empty = (sp_ff == '0);
    wire core_op   = call_push | ret_pop | return_from_interrupt;
    wire accept    = global_irq_enable_ff & ~stack_full & insn_boundary & ~core_op
                   & (|pend);
    wire do_pop    = (ret_pop | return_from_interrupt) & ~stk_empty;
    wire do_push   = accept | (call_push & ~stack_full);
    wire [irqc_pkg::N_SRC-1:0] svc_clr = accept ? (SRC_ONE << sel_idx) : '0;
    wire [irqc_pkg::SP_W-1:0]  sp_dec  = sp_ff - 1'b1;
    assign stack_full = (sp_ff == irqc_pkg::SP_W'(irqc_pkg::STK_DEPTH));

    // Next flag values: set beats any clear, write beats service clear
    wire [irqc_pkg::N_EXT-1:0] nxt_ext_flag = ext_hit
        | (wr_ext ? pwdata[irqc_pkg::FLAG_LSB +: irqc_pkg::N_EXT]
                  : (ext_pin_request_flag_ff & ~svc_clr[irqc_pkg::SRC_EXT0 +: irqc_pkg::N_EXT]));
    wire [irqc_pkg::N_GRP-1:0] nxt_grp_flag = grp_evt
        | (wr_grp ? pwdata[irqc_pkg::FLAG_LSB +: irqc_pkg::N_GRP]
                  : (shared_group_request_flag_ff
                     & ~svc_clr[irqc_pkg::SRC_GRP0 +: irqc_pkg::N_GRP]));
    wire nxt_conv_flag = conv_done
        | (wr_conv ? pwdata[irqc_pkg::CONV_F_BIT]
                   : (conv_done_request_flag_ff & ~svc_clr[irqc_pkg::SRC_CONV]));
    // Member flags have no service clear at all
    wire [2*irqc_pkg::N_TM-1:0] nxt_tm_flag = tm_evt
        | (wr_tm ? pwdata[irqc_pkg::TM_F_LSB +: 2*irqc_pkg::N_TM] : tm_flag_ff);
    wire [3:0] nxt_aux_flag = aux_evt
        | (wr_aux ? pwdata[irqc_pkg::FLAG_LSB +: 4] : aux_flag_ff);
    wire nxt_gie = wr_gie ? pwdata[irqc_pkg::GIE_BIT]
                 : (accept ? 1'b0 : global_irq_enable_ff);

    // Every flag in one word for wake detection
    wire [irqc_pkg::N_ALLF-1:0] all_flags = {aux_flag_ff, tm_flag_ff,
                                             src_flags};

    // Request flags, events latch regardless of enables, except pin edges, which need the pin enable
    always_ff @(posedge clk_sys or negedge rst_core_n) begin
        if (!rst_core_n) begin
            ext_pin_request_flag_ff      <= '0;
            shared_group_request_flag_ff <= '0;
            conv_done_request_flag_ff    <= 1'b0;
            tm_flag_ff                   <= '0;
            aux_flag_ff                  <= irqc_pkg::RST_BYTE[7:4];
        end else begin
            ext_pin_request_flag_ff      <= nxt_ext_flag;
            shared_group_request_flag_ff <= nxt_grp_flag;
            conv_done_request_flag_ff    <= nxt_conv_flag;
            tm_flag_ff                   <= nxt_tm_flag;
            aux_flag_ff                  <= nxt_aux_flag;
        end
    end

    // Enables and edge select, written by software only; accept also clears the global enable
    always_ff @(posedge clk_sys or negedge rst_core_n) begin
        if (!rst_core_n) begin
            global_irq_enable_ff   <= 1'b0;
            edge_sel_ff            <= irqc_pkg::RST_BYTE;
            ext_pin_irq_enable_ff  <= '0;
            shared_group_enable_ff <= '0;
            conv_done_irq_enable_ff <= 1'b0;
            tm_en_ff               <= '0;
            aux_en_ff              <= irqc_pkg::RST_BYTE[3:0];
        end else begin
            global_irq_enable_ff <= nxt_gie;
            if (wr_edge) edge_sel_ff <= pwdata[7:0];
            if (wr_ext) ext_pin_irq_enable_ff <= pwdata[irqc_pkg::N_EXT-1:0];
            if (wr_grp) shared_group_enable_ff <= pwdata[irqc_pkg::N_GRP-1:0];
            if (wr_conv) conv_done_irq_enable_ff <= pwdata[irqc_pkg::CONV_E_BIT];
            if (wr_tm) tm_en_ff <= pwdata[2*irqc_pkg::N_TM-1:0];
            if (wr_aux) aux_en_ff <= pwdata[3:0];
        end
    end

    // Return stack storage, no reset needed
    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            stk_mem[sp_ff[irqc_pkg::SP_W-2:0]] <= next_pc;
        end
    end

    // Stack pointer and program counter redirection
    always_ff @(posedge clk_sys or negedge rst_core_n) begin
        if (!rst_core_n) begin
            sp_ff           <= '0;
            pc_load_ff      <= 1'b0;
            pc_load_addr_ff <= '0;
            irq_taken_ff    <= 1'b0;
            last_src_ff     <= '0;
        end else begin
            pc_load_ff   <= accept | do_pop;
            irq_taken_ff <= accept;
            if (do_push) begin
                sp_ff <= sp_ff + 1'b1;
            end else if (do_pop) begin
                sp_ff <= sp_dec;
            end
            if (accept) begin
                pc_load_addr_ff <= irqc_pkg::VEC_TABLE[sel_idx];
                last_src_ff     <= sel_idx;
            end else if (do_pop) begin
                pc_load_addr_ff <= stk_mem[sp_dec[irqc_pkg::SP_W-2:0]];
            end
        end
    end

    // Wake pulse on any flag rising
    always_ff @(posedge clk_sys or negedge rst_core_n) begin
        if (!rst_core_n) begin
            prev_flags_ff <= '0;
            wake_ff       <= 1'b0;
        end else begin
            prev_flags_ff <= all_flags;
            wake_ff       <= |(all_flags & ~prev_flags_ff);
        end
    end

    assign pc_load      = pc_load_ff;
    assign pc_load_addr = pc_load_addr_ff;
    assign irq_taken    = irq_taken_ff;
    assign wake_req     = wake_ff;

    // Read mux
    logic [31:0] rd_word;
    always_comb begin
        rd_word = '0;
        if (paddr == irqc_pkg::OFS_GIE) begin
            rd_word[irqc_pkg::GIE_BIT] = global_irq_enable_ff;
        end else if (paddr == irqc_pkg::OFS_EDGE) begin
            rd_word[7:0] = edge_sel_ff;
        end else if (paddr == irqc_pkg::OFS_EXT) begin
            rd_word[7:0] = {ext_pin_request_flag_ff, ext_pin_irq_enable_ff};
        end else if (paddr == irqc_pkg::OFS_GRP) begin
            rd_word[7:0] = {shared_group_request_flag_ff, shared_group_enable_ff};
        end else if (paddr == irqc_pkg::OFS_CONV) begin
            rd_word[1:0] = {conv_done_request_flag_ff, conv_done_irq_enable_ff};
        end else if (paddr == irqc_pkg::OFS_TM) begin
            rd_word[15:0] = {tm_flag_ff, tm_en_ff};
        end else if (paddr == irqc_pkg::OFS_AUX) begin
            rd_word[7:0] = {aux_flag_ff, aux_en_ff};
        end else if (paddr == irqc_pkg::OFS_STAT) begin
            rd_word[irqc_pkg::SP_W-1:0] = sp_ff;
            rd_word[irqc_pkg::STAT_FULL] = stack_full;
            rd_word[irqc_pkg::STAT_SRC +: irqc_pkg::SEL_W] = last_src_ff;
        end
    end

    // Read data captured in the setup phase
    always_ff @(posedge clk_sys or negedge rst_core_n) begin
        if (!rst_core_n) begin
            prdata_ff <= '0;
        end else if (apb_setup) begin
            prdata_ff <= rd_word;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_core_n);

    sequence take_s;
        accept;
    endsequence

    sequence redirect_s(logic [irqc_pkg::PC_W-1:0] a);
        pc_load_ff && (pc_load_addr_ff == a);
    endsequence

    conv_flag_set_a: assert property (conv_done |=> conv_done_request_flag_ff)
        else $error("conversion event did not set its flag");
    enabled_only_a: assert property (take_s |-> src_en[sel_idx] && src_flags[sel_idx])
        else $error("vector taken for disabled source");
    global_gate_a: assert property (!global_irq_enable_ff |-> !accept)
        else $error("vector taken with global enable low");
    vector_load_a: assert property (take_s ##1 1'b1 |->
        redirect_s(irqc_pkg::VEC_TABLE[$past(sel_idx)]))
        else $error("vector address not loaded");
    return_from_interrupt_pop_a: assert property (return_from_interrupt && !stk_empty |=>
        pc_load_ff && sp_ff == $past(sp_dec))
        else $error("return did not pop the stack");
    gie_clear_a: assert property (take_s and !wr_gie |=> !global_irq_enable_ff)
        else $error("global enable not cleared on service");
    full_block_a: assert property (stack_full |-> !accept ##1 !irq_taken_ff)
        else $error("request accepted with full stack");
    priority_pick_a: assert property (take_s |->
        (pend & ((SRC_ONE << sel_idx) - SRC_ONE)) == '0)
        else $error("lower priority source chosen");
    wake_rise_a: assert property ($rose(conv_done_request_flag_ff) |=> wake_ff)
        else $error("flag rise gave no wake pulse");
    pin_clear_a: assert property (accept && !wr_ext && ext_hit == '0
        && sel_idx < irqc_pkg::SRC_GRP0 |=> !ext_pin_request_flag_ff[$past(sel_idx[1:0])])
        else $error("pin flag not cleared on service");
    grp_clear_a: assert property (accept && !wr_grp && grp_evt == '0
        && sel_idx >= irqc_pkg::SRC_GRP0 && sel_idx < irqc_pkg::SRC_CONV
        |=> !shared_group_request_flag_ff[$past(sel_idx[1:0])])
        else $error("group flag not cleared on service");
    conv_clear_a: assert property (accept && !wr_conv && !conv_done
        && sel_idx == irqc_pkg::SRC_CONV |=> !conv_done_request_flag_ff)
        else $error("converter flag not cleared on service");
    member_keep_a: assert property (accept && !wr_tm |=>
        tm_flag_ff == ($past(tm_flag_ff) | $past(tm_evt)))
        else $error("member flag cleared by service");
    group_join_a: assert property ((|aux_evt) |=>
        shared_group_request_flag_ff[irqc_pkg::AUX_GROUP])
        else $error("aux event did not set its group flag");
endmodule

// File: inc/irqc_pkg.sv
// Constants, register map and vector table for the interrupt controller.
// Assumes an APB register port and a core that samples the vector load port.
// Overview of operation
// - Source events always set their request flag; pin edges only while the pin is enabled
// - Disabled source keeps flag, never vectors; member enables gate nothing, a disabled member still sets its group
// - Global enable low blocks all vectoring
// - Accept pushes next PC, loads vector
// - Return pops saved address into PC
// - Servicing clears the global enable
// - Flags still latch while servicing
// - Full stack blocks acceptance until pop
// - Simultaneous requests resolved by fixed priority
// - Any flag set wakes from sleep
// - Pin flag set on selected edge type
// - Pin takes interrupt role only when enabled
// - Pin service clears its flag and global
// - Four shared groups aggregate member sources
// - Member flag set also sets group flag
// - Group service clears group flag, global
// - Member flags stay set, software clears
// - Conversion done sets flag, may vector
// - Converter service clears its flag, global
// - Aux register: flags 7..4, enables 3..0
// - Edge select 00 off,01 rise,10 fall,11 both
// - Global enable is bit 0, resets 0
// - Wake on any flag low-to-high change
package irqc_pkg;
    // Sizes
    localparam int N_EXT     = 4;           // External pins
    localparam int N_GRP     = 4;           // Shared groups
    localparam int N_TM      = 4;           // Timer modules, two matches each
    localparam int N_SRC     = 9;           // Vectored sources
    localparam int N_ALLF    = 21;          // Every request flag
    localparam int PC_W      = 13;          // Program counter width
    localparam int STK_DEPTH = 8;           // Return stack depth
    localparam int SP_W      = 4;           // Stack pointer width
    localparam int SEL_W     = 4;           // Source index width
    localparam int ADDR_W    = 8;           // APB address width

    // Register byte offsets
    localparam logic [7:0] OFS_GIE  = 8'h00;
    localparam logic [7:0] OFS_EDGE = 8'h04;
    localparam logic [7:0] OFS_EXT  = 8'h08;
    localparam logic [7:0] OFS_GRP  = 8'h0c;
    localparam logic [7:0] OFS_CONV = 8'h10;
    localparam logic [7:0] OFS_TM   = 8'h14;
    localparam logic [7:0] OFS_AUX  = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1c;

    // Field positions
    localparam int GIE_BIT    = 0;
    localparam int FLAG_LSB   = 4;          // Flags of ext, grp and aux words
    localparam int CONV_F_BIT = 1;
    localparam int CONV_E_BIT = 0;
    localparam int TM_F_LSB   = 8;
    localparam int STAT_FULL  = 4;
    localparam int STAT_SRC   = 8;

    // Reset value of every control byte
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Edge select codes
    localparam logic [1:0] EDGE_OFF  = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // Source indices, lower index wins
    localparam int SRC_EXT0 = 0;
    localparam int SRC_GRP0 = 4;
    localparam int SRC_CONV = 8;

    // Group that holds the four aux sources
    localparam int AUX_GROUP = 3;

    // Vector address of each source index
    localparam logic [PC_W-1:0] VEC_TABLE [N_SRC] = '{
        13'h0004, 13'h0008, 13'h000c, 13'h0010,
        13'h0014, 13'h0018, 13'h001c, 13'h0020, 13'h0024};
endpackage

// File: hw/irq_edge_detect.sv
// Edge detectors for the external interrupt pins.
// Assumes pins already synchronous to clk_sys and a synchronised reset.
`timescale 1ns/10ps
module irq_edge_detect (
    input  wire logic                         clk_sys,
    input  wire logic                         rst_core_n,
    input  wire logic [irqc_pkg::N_EXT-1:0]   pin_in,
    input  wire logic [2*irqc_pkg::N_EXT-1:0] edge_sel,
    input  wire logic [irqc_pkg::N_EXT-1:0]   pin_en,
    output logic      [irqc_pkg::N_EXT-1:0]   edge_hit
);
    logic [irqc_pkg::N_EXT-1:0] prev_ff;    // Pin level one cycle ago
    logic                       prime_ff;   // History valid after reset

    // Keep last pin level; prime blocks a false edge right after reset
    always_ff @(posedge clk_sys or negedge rst_core_n) begin
        if (!rst_core_n) begin
            prev_ff  <= '0;
            prime_ff <= 1'b0;
        end else begin
            prev_ff  <= pin_in;
            prime_ff <= 1'b1;
        end
    end

    // One detector per pin
    genvar g;
    generate
        for (g = 0; g < irqc_pkg::N_EXT; g++) begin : g_pin
            wire       rise = pin_in[g] & ~prev_ff[g];
            wire       fall = ~pin_in[g] & prev_ff[g];
            wire [1:0] sel  = edge_sel[2*g +: 2];
            wire       match = ((sel == irqc_pkg::EDGE_RISE) & rise)
                             | ((sel == irqc_pkg::EDGE_FALL) & fall)
                             | ((sel == irqc_pkg::EDGE_BOTH) & (rise | fall));
            // Pin only acts as an interrupt input while enabled
            assign edge_hit[g] = prime_ff & pin_en[g] & match;
        end
    endgenerate
endmodule

// File: dv/irqc_core_model.sv
// Core fetch model: offers instruction boundaries, pauses after a redirect.
// Assumes pc_load is a one-cycle pulse on clk_sys.
`timescale 1ns/10ps
module irqc_core_model (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic pc_load,
    output logic      insn_boundary
);
    logic [1:0] hold_ff; // Cycles left before the next boundary
    // Pause two cycles so a redirect is consumed before another one
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) hold_ff <= 2'h0;
        else if (pc_load) hold_ff <= 2'h2;
        else if (hold_ff != 2'h0) hold_ff <= hold_ff - 2'h1;
    end
    assign insn_boundary = rst_n && !pc_load && hold_ff == 2'h0;
endmodule

// File: dv/mcu_interrupt_controller_tb.sv
// Self-checking bench: APB software, event pulses, core model, vector queue.
// Assumes zero-wait APB and one-cycle pc_load pulses from the design.
`timescale 1ns/10ps
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin n_fail++; \
    $display("ERROR %s exp %h got %h", nm, e, s); end end
module mcu_interrupt_controller_tb;
    logic        clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic        pready, pslverr, rerr, pc_load, irq_taken, stack_full, wake_req, insn_b;
    logic [3:0]  pins = 4'h0, pin_sel;
    logic [15:0] evt = 16'h0;             // One pulse line per event input
    logic [12:0] pcv = 13'h0, pc_load_addr;
    logic [31:0] rs = 32'heb32;           // Xorshift state
    logic [13:0] expq[$], exp_pc;         // Expected {irq_taken, redirect address}
    int          n_fail = 0, cmp_count = 0, wakes = 0, w0;
    always #2 clk_sys = ~clk_sys;
    mcu_interrupt_controller mcu_interrupt_controller_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_pin_in(pins),
        .tm_match_a(evt[11:8]), .tm_match_p(evt[15:12]), .tb0_tick(evt[5]),
        .tb1_tick(evt[1]), .nvm_write_done(evt[6]), .low_voltage_evt(evt[7]),
        .conv_done(evt[0]), .insn_boundary(insn_b), .next_pc(pcv), .call_push(evt[2]),
        .ret_pop(evt[3]), .return_from_interrupt(evt[4]), .pc_load(pc_load),
        .pc_load_addr(pc_load_addr), .irq_taken(irq_taken), .stack_full(stack_full),
        .wake_req(wake_req), .ext_pin_func_sel(pin_sel));
    irqc_core_model irqc_core_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .pc_load(pc_load),
        .insn_boundary(insn_b));
    // Monitor: every redirect must match the oldest expected address
    always @(posedge clk_sys) begin
        if (wake_req === 1'b1) wakes++;
        if (pc_load === 1'b1 && expq.size() == 0) `CHK("unexpected pc_load", 1'b0, 1'b1)
        else if (pc_load === 1'b1) begin
            exp_pc = expq.pop_front();
            `CHK("pc_load_addr", exp_pc[12:0], pc_load_addr)
            `CHK("irq_taken", exp_pc[13], irq_taken)
        end
    end
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    // One APB transfer: setup, then access until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rdat = prdata; rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er);
        apb(1'b0, a, 32'h0);
        `CHK("prdata", e, rdat)
        `CHK("pslverr", er, rerr)
    endtask
    task automatic pulse(input int k);
        @(posedge clk_sys) evt <= 16'h1 << k;
        @(posedge clk_sys) evt <= 16'h0;
    endtask
    task automatic drain();
        for (int i = 0; i < 40 && expq.size() != 0; i++) @(posedge clk_sys);
        `CHK("queue left", 0, expq.size())
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        give_verdict();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        pcv <= 13'(rnd() % 32'h1000);
        repeat (3) @(posedge clk_sys);
        rd(irqc_pkg::OFS_AUX, 32'h0, 1'b0);
        rd(irqc_pkg::OFS_GIE, 32'h0, 1'b0);
        rd(8'h20, 32'h0, 1'b1);
        w0 = wakes;
        pulse(0);
        repeat (3) @(posedge clk_sys);
        `CHK("wakes", w0 + 1, wakes)
        rd(irqc_pkg::OFS_CONV, 32'h2, 1'b0);
        wr(irqc_pkg::OFS_CONV, 32'h3);
        expq.push_back({1'b1, irqc_pkg::VEC_TABLE[irqc_pkg::SRC_CONV]});
        wr(irqc_pkg::OFS_GIE, 32'h1);
        drain();
        rd(irqc_pkg::OFS_GIE, 32'h0, 1'b0);
        rd(irqc_pkg::OFS_CONV, 32'h1, 1'b0);
        for (int c = 0; c < 4; c++) begin
            wr(irqc_pkg::OFS_EDGE, 32'(c));
            wr(irqc_pkg::OFS_EXT, 32'h1);
            @(posedge clk_sys) `CHK("pin_sel", 4'h1, pin_sel)
            @(posedge clk_sys) pins[0] <= 1'b1;
            rd(irqc_pkg::OFS_EXT, 32'h1 | (32'(c & 1) << 4), 1'b0);
            wr(irqc_pkg::OFS_EXT, 32'h1);
            @(posedge clk_sys) pins[0] <= 1'b0;
            rd(irqc_pkg::OFS_EXT, 32'h1 | (32'(c >> 1) << 4), 1'b0);
            wr(irqc_pkg::OFS_EXT, 32'h1);
        end
        wr(irqc_pkg::OFS_EDGE, 32'h4);
        wr(irqc_pkg::OFS_EXT, 32'h2);
        pulse(0);
        @(posedge clk_sys) pins[1] <= 1'b1;
        expq.push_back({1'b1, irqc_pkg::VEC_TABLE[1]});
        expq.push_back({1'b1, irqc_pkg::VEC_TABLE[irqc_pkg::SRC_CONV]});
        wr(irqc_pkg::OFS_GIE, 32'h1);
        rd(irqc_pkg::OFS_EXT, 32'h2, 1'b0);
        wr(irqc_pkg::OFS_GIE, 32'h1);
        drain();
        wr(irqc_pkg::OFS_AUX, 32'h0);
        pulse(1);
        rd(irqc_pkg::OFS_AUX, 32'h80, 1'b0);
        rd(irqc_pkg::OFS_GRP, 32'h80, 1'b0);
        wr(irqc_pkg::OFS_GRP, 32'h88);
        expq.push_back({1'b1, irqc_pkg::VEC_TABLE[irqc_pkg::SRC_GRP0 + irqc_pkg::AUX_GROUP]});
        wr(irqc_pkg::OFS_GIE, 32'h1);
        drain();
        rd(irqc_pkg::OFS_GRP, 32'h08, 1'b0);
        rd(irqc_pkg::OFS_AUX, 32'h80, 1'b0);
        repeat (8) pulse(2);
        @(posedge clk_sys) `CHK("stack_full", 1'b1, stack_full)
        pulse(0);
        wr(irqc_pkg::OFS_GIE, 32'h1);
        repeat (10) @(posedge clk_sys);
        expq.push_back({1'b0, pcv});
        expq.push_back({1'b1, irqc_pkg::VEC_TABLE[irqc_pkg::SRC_CONV]});
        pulse(3);
        drain();
        expq.push_back({1'b0, pcv});
        pulse(4);
        drain();
        give_verdict();
    end
endmodule
